// >>> sbm_intmsg.sv
// Converts module interrupt line changes into upstream interrupt messages.
`timescale 1ns/10ps
module sbm_intmsg #(
  parameter int LINES = 4
) (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     reset_n,
  // Synchronised line levels, high while a line is asserted
  input  wire logic [LINES-1:0]         line_active,
  // Message handshake toward the upstream link
  output logic                          msg_valid,
  input  wire logic                     msg_ready,
  output logic [$clog2(LINES)-1:0]      msg_line,
  output logic                          msg_assert
);

  localparam int LW = $clog2(LINES);

  typedef struct packed {
    logic [LINES-1:0] sent;
    logic             busy;
    logic [LW-1:0]    line;
    logic             asrt;
  } sbm_intmsg_state_t;

  sbm_intmsg_state_t cur;
  sbm_intmsg_state_t next_cur;
  logic [LINES-1:0]  diff;

  // A line needs a message whenever its level differs from the last level reported.
  genvar gi;
  generate
    for (gi = 0; gi < LINES; gi++) begin : g_diff
      assign diff[gi] = line_active[gi] ^ cur.sent[gi];
    end
  endgenerate

  // One message in flight; the lowest numbered changed line goes first.
  always_comb begin
    logic          found;
    logic [LW-1:0] pick;
    found    = 1'b0;
    pick     = '0;
    next_cur = cur;
    for (int i = LINES - 1; i >= 0; i--) begin
      if (diff[i]) begin
        found = 1'b1;
        pick  = i[LW-1:0];
      end
    end
    if (cur.busy && msg_ready) begin
      next_cur.busy = 1'b0;
    end else if (!cur.busy && found) begin
      next_cur.busy       = 1'b1;
      next_cur.line       = pick;
      next_cur.asrt       = line_active[pick];
      next_cur.sent[pick] = line_active[pick];
    end
  end

  // Register the message state.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign msg_valid  = cur.busy;
  assign msg_line   = cur.line;
  assign msg_assert = cur.asrt;

  // A waiting message must hold its contents until taken.
  sequence msg_wait_s;
    msg_valid && !msg_ready;
  endsequence

  msg_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    msg_wait_s |=> msg_valid && $stable(msg_line) && $stable(msg_assert))
    else $error("Interrupt message changed before it was taken.");

  msg_launch_a: assert property (@(posedge clk) disable iff (!reset_n)
    !msg_valid && (|diff) |=> msg_valid)
    else $error("Interrupt line change did not raise a message.");

endmodule // sbm_intmsg

// >>> sbm_pkg.sv
// Shared constants and types for the secondary bus mode and frequency strap logic.
package sbm_pkg;

  // ************************************************************
  // Switch bank positions, index 0 is position one
  // ************************************************************
  localparam int SW_COUNT    = 8;
  localparam int SW_CAP_JOIN = 0;
  localparam int SW_CAP_GND  = 1;
  localparam int SW_CAP_MID  = 2;
  localparam int SW_RATE     = 3;
  localparam int SW_M66_JOIN = 4;
  localparam int SW_M66_GND  = 5;
  localparam int SW_WIDTH32  = 6;
  localparam int SW_HOST     = 7;

  // ************************************************************
  // Bus rates in MHz, three lower/upper pairs picked by capability level and speed66
  // ************************************************************
  localparam logic [7:0] FREQ_25  = 8'h19;
  localparam logic [7:0] FREQ_33  = 8'h21;
  localparam logic [7:0] FREQ_50  = 8'h32;
  localparam logic [7:0] FREQ_66  = 8'h42;
  localparam logic [7:0] FREQ_100 = 8'h64;
  localparam logic [7:0] FREQ_133 = 8'h85;

  // ************************************************************
  // Slot wiring and synchroniser layout
  // ************************************************************
  localparam int AD_WIDTH     = 32;
  localparam int IDSEL_AD_BIT = 20;
  localparam int INT_LINES    = 4;
  localparam int SYNC_WIDTH   = 15;
  // Switches open, comparators high, speed line released, interrupts idle.
  localparam logic [SYNC_WIDTH-1:0] SYNC_RESET = 15'h7F00;

  // Capability line levels, ordered so that the lower level wins when joined.
  typedef enum logic [1:0] {SBM_LVL_GND, SBM_LVL_MID, SBM_LVL_HIGH} sbm_level_t;

  // Strap latch phases around the secondary bus reset.
  typedef enum logic {SBM_ST_SAMPLE, SBM_ST_HOLD} sbm_latch_t;

endpackage

// >>> sbm_pmc_model.sv
// Behavioural mezzanine module on the far side of the strap and interrupt pins.
`timescale 1ns/10ps
module sbm_pmc_model (
  // Module behaviour chosen by the bench
  input  wire sbm_pkg::sbm_level_t mod_level,
  input  wire logic                mod_slow66,
  input  wire logic [3:0]          mod_int_req_n,
  // Bridge pull controls
  input  wire logic                cap_gnd_oe_n,
  input  wire logic                cap_mid_en,
  input  wire logic                speed66_oe_n,
  // Pin levels seen by the bridge
  output logic                     cap_above_low,
  output logic                     cap_above_mid,
  output logic                     speed66_line,
  output logic [3:0]               int_n
);
  sbm_pkg::sbm_level_t line_level;

  // The strongest pull on the shared line wins, so ground beats the divider.
  always_comb begin
    line_level = mod_level;
    if (cap_mid_en && line_level == sbm_pkg::SBM_LVL_HIGH) begin
      line_level = sbm_pkg::SBM_LVL_MID;
    end
    if (!cap_gnd_oe_n) begin
      line_level = sbm_pkg::SBM_LVL_GND;
    end
  end
  assign cap_above_low = (line_level != sbm_pkg::SBM_LVL_GND);
  assign cap_above_mid = (line_level == sbm_pkg::SBM_LVL_HIGH);
  // Pulled up, so the line reads one only while nobody pulls it low.
  assign speed66_line  = !(mod_slow66 || !speed66_oe_n);
  assign int_n         = mod_int_req_n;
endmodule // sbm_pmc_model

// >>> sbm_strap_ctrl.sv
// Secondary bus mode, rate, width and slot strap control for the bridge.
`timescale 1ns/10ps
module sbm_strap_ctrl (
  // Clock and reset
  input  wire logic                              clk,
  input  wire logic                              reset_n,
  // Switch bank, one bit per position, high while closed
  input  wire logic [sbm_pkg::SW_COUNT-1:0]      config_switch_bank,
  // Module capability line comparators
  input  wire logic                              module_cap_above_low,
  input  wire logic                              module_cap_above_mid,
  // Module capability line pull controls
  output logic                                   module_cap_gnd_oe_n,
  output logic                                   module_cap_mid_en,
  // Resolved bridge capability line
  output sbm_pkg::sbm_level_t                    bridge_capability_line,
  // Module speed66 line, open drain
  input  wire logic                              module_speed66_enable_in,
  output logic                                   module_speed66_enable_out,
  output logic                                   module_speed66_enable_oe_n,
  // Resolved bridge speed66 line and rate pair select
  output logic                                   bridge_speed66_enable,
  output logic                                   rate_pair_select,
  // Host-role strap, open drain
  output logic                                   host_role_out,
  output logic                                   host_role_oe_n,
  // Secondary bus reset from the bridge core
  input  wire logic                              sec_reset_n,
  // Latched bus configuration
  output logic                                   bus_pcix_mode,
  output logic [7:0]                             bus_freq_mhz,
  output logic                                   bus_64bit,
  output logic                                   config_held,
  // Module interrupt lines, active low
  input  wire logic [sbm_pkg::INT_LINES-1:0]     module_int_n,
  // Upstream interrupt messages
  output logic                                   int_msg_valid,
  input  wire logic                              int_msg_ready,
  output logic [$clog2(sbm_pkg::INT_LINES)-1:0]  int_msg_line,
  output logic                                   int_msg_assert,
  // Secondary address/data bus and slot configuration select
  input  wire logic [sbm_pkg::AD_WIDTH-1:0]      ad_bus,
  output logic                                   config_select
);

  // ************************************************************
  // State and synchronised inputs
  // ************************************************************

  typedef struct packed {
    sbm_pkg::sbm_latch_t st;
    sbm_pkg::sbm_level_t cap;
    logic                br_m66;
    logic                mod_m66_oe_n;
    logic                cap_gnd_oe_n;
    logic                cap_mid_en;
    logic                rate_sel;
    logic                host_oe_n;
    logic                pcix;
    logic [7:0]          freq;
    logic                bus64;
  } sbm_core_state_t;

  // Released lines, highest capability and lowest rate until the first sample.
  localparam sbm_core_state_t CORE_RESET = '{
    st:           sbm_pkg::SBM_ST_SAMPLE,
    cap:          sbm_pkg::SBM_LVL_HIGH,
    br_m66:       1'b1,
    mod_m66_oe_n: 1'b1,
    cap_gnd_oe_n: 1'b1,
    cap_mid_en:   1'b0,
    rate_sel:     1'b1,
    host_oe_n:    1'b1,
    pcix:         1'b0,
    freq:         sbm_pkg::FREQ_25,
    bus64:        1'b0
  };

  sbm_core_state_t                    cur;
  sbm_core_state_t                    next_cur;
  logic [sbm_pkg::SYNC_WIDTH-1:0]     pins_raw;
  logic [sbm_pkg::SYNC_WIDTH-1:0]     pins_s;
  logic [sbm_pkg::SW_COUNT-1:0]       sw;
  logic                               mod_above_low;
  logic                               mod_above_mid;
  logic                               mod_m66;
  logic [sbm_pkg::INT_LINES-1:0]      int_n_s;
  sbm_pkg::sbm_level_t                mod_lvl;
  sbm_pkg::sbm_level_t                local_lvl;
  sbm_pkg::sbm_level_t                cap_resolved;
  logic                               m66_resolved;
  logic                               upper_rate;
  logic                               dec_pcix;
  logic [7:0]                         dec_freq;

  // All strap, speed and interrupt pins cross in one synchroniser bank.
  assign pins_raw = {module_int_n, module_speed66_enable_in, module_cap_above_mid,
                     module_cap_above_low, config_switch_bank};

  sbm_sync #(
    .WIDTH     (sbm_pkg::SYNC_WIDTH),
    .RESET_VAL (sbm_pkg::SYNC_RESET)
  ) u_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .pin      (pins_raw),
    .pin_sync (pins_s)
  );

  // Unpack the synchronised bank into named fields.
  assign sw            = pins_s[sbm_pkg::SW_COUNT-1:0];
  assign mod_above_low = pins_s[sbm_pkg::SW_COUNT];
  assign mod_above_mid = pins_s[sbm_pkg::SW_COUNT+1];
  assign mod_m66       = pins_s[sbm_pkg::SW_COUNT+2];
  assign int_n_s       = pins_s[sbm_pkg::SYNC_WIDTH-1:sbm_pkg::SW_COUNT+3];

  // ************************************************************
  // Capability line resolution
  // ************************************************************

  // Module side level seen through the two comparators.
  always_comb begin
    if (!mod_above_low) begin
      mod_lvl = sbm_pkg::SBM_LVL_GND;
    end else if (!mod_above_mid) begin
      mod_lvl = sbm_pkg::SBM_LVL_MID;
    end else begin
      mod_lvl = sbm_pkg::SBM_LVL_HIGH;
    end
  end

  // Bridge side level set by the ground and divider positions alone.
  always_comb begin
    if (sw[sbm_pkg::SW_CAP_GND]) begin
      local_lvl = sbm_pkg::SBM_LVL_GND;
    end else if (sw[sbm_pkg::SW_CAP_MID]) begin
      local_lvl = sbm_pkg::SBM_LVL_MID;
    end else begin
      local_lvl = sbm_pkg::SBM_LVL_HIGH;
    end
  end

  // When joined the lowest level wins, so a grounding module beats the divider.
  always_comb begin
    if (sw[sbm_pkg::SW_CAP_JOIN] && (mod_lvl < local_lvl)) begin
      cap_resolved = mod_lvl;
    end else begin
      cap_resolved = local_lvl;
    end
  end

  // ************************************************************
  // Speed66 wired-AND and rate pair
  // ************************************************************

  // Released reads one; the forced ground or a joined module pull lowers it.
  assign m66_resolved = !sw[sbm_pkg::SW_M66_GND] &&
                        !(sw[sbm_pkg::SW_M66_JOIN] && !mod_m66);

  // A closed rate switch grounds the select line and asks for the upper rate.
  assign upper_rate = sw[sbm_pkg::SW_RATE];

  // ************************************************************
  // Mode and frequency decode
  // ************************************************************

  // Clock rate follows only the strap levels, never the upstream link.
  always_comb begin
    dec_pcix = 1'b0;
    dec_freq = sbm_pkg::FREQ_25;
    unique case (cap_resolved)
      sbm_pkg::SBM_LVL_GND: begin
        dec_pcix = 1'b0;
        if (m66_resolved) begin
          dec_freq = upper_rate ? sbm_pkg::FREQ_66 : sbm_pkg::FREQ_50;
        end else begin
          dec_freq = upper_rate ? sbm_pkg::FREQ_33 : sbm_pkg::FREQ_25;
        end
      end
      sbm_pkg::SBM_LVL_MID: begin
        dec_pcix = 1'b1;
        dec_freq = upper_rate ? sbm_pkg::FREQ_66 : sbm_pkg::FREQ_50;
      end
      sbm_pkg::SBM_LVL_HIGH: begin
        dec_pcix = 1'b1;
        dec_freq = upper_rate ? sbm_pkg::FREQ_133 : sbm_pkg::FREQ_100;
      end
      default: begin
        dec_pcix = 1'b0;
        dec_freq = sbm_pkg::FREQ_25;
      end
    endcase
  end

  // ************************************************************
  // Next state
  // ************************************************************

  // Line drives track the switches live; the bus configuration only moves
  // while the secondary bus is in reset, since a mid-run change would break it.
  always_comb begin
    next_cur              = cur;
    next_cur.cap          = cap_resolved;
    next_cur.br_m66       = m66_resolved;
    next_cur.cap_gnd_oe_n = !(sw[sbm_pkg::SW_CAP_JOIN] && sw[sbm_pkg::SW_CAP_GND]);
    next_cur.cap_mid_en   = sw[sbm_pkg::SW_CAP_JOIN] && sw[sbm_pkg::SW_CAP_MID];
    next_cur.mod_m66_oe_n = !(sw[sbm_pkg::SW_M66_JOIN] && sw[sbm_pkg::SW_M66_GND]);
    next_cur.rate_sel     = !upper_rate;
    next_cur.host_oe_n    = !sw[sbm_pkg::SW_HOST];
    unique case (cur.st)
      sbm_pkg::SBM_ST_SAMPLE: begin
        next_cur.pcix  = dec_pcix;
        next_cur.freq  = dec_freq;
        next_cur.bus64 = !sw[sbm_pkg::SW_WIDTH32];
        if (sec_reset_n) begin
          next_cur.st = sbm_pkg::SBM_ST_HOLD;
        end
      end
      sbm_pkg::SBM_ST_HOLD: begin
        if (!sec_reset_n) begin
          next_cur.st = sbm_pkg::SBM_ST_SAMPLE;
        end
      end
    endcase
  end

  // Register the whole state.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cur <= CORE_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************

  // Open-drain lines only ever drive low; the pull-ups give the high level.
  assign module_cap_gnd_oe_n        = cur.cap_gnd_oe_n;
  assign module_cap_mid_en          = cur.cap_mid_en;
  assign bridge_capability_line     = cur.cap;
  assign module_speed66_enable_out  = 1'b0;
  assign module_speed66_enable_oe_n = cur.mod_m66_oe_n;
  assign bridge_speed66_enable      = cur.br_m66;
  assign rate_pair_select           = cur.rate_sel;
  assign host_role_out              = 1'b0;
  assign host_role_oe_n             = cur.host_oe_n;
  assign bus_pcix_mode              = cur.pcix;
  assign bus_freq_mhz               = cur.freq;
  assign bus_64bit                  = cur.bus64;
  assign config_held                = (cur.st == sbm_pkg::SBM_ST_HOLD);

  // Routed strap: the slot select is a plain wire from one address line.
  assign config_select = ad_bus[sbm_pkg::IDSEL_AD_BIT];

  // ************************************************************
  // Interrupt forwarding
  // ************************************************************

  sbm_intmsg #(
    .LINES (sbm_pkg::INT_LINES)
  ) u_intmsg (
    .clk         (clk),
    .reset_n     (reset_n),
    .line_active (~int_n_s),
    .msg_valid   (int_msg_valid),
    .msg_ready   (int_msg_ready),
    .msg_line    (int_msg_line),
    .msg_assert  (int_msg_assert)
  );

  // ************************************************************
  // Checks
  // ************************************************************

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence bus_reset_release_s;
    !sec_reset_n ##1 sec_reset_n;
  endsequence

  sequence held_run_s;
    sec_reset_n [*2];
  endsequence

  cap_ground_a: assert property (
    sw[sbm_pkg::SW_CAP_GND] |=> bridge_capability_line == sbm_pkg::SBM_LVL_GND)
    else $error("Grounded capability switch did not ground the bridge line.");

  cap_isolate_a: assert property (
    !sw[sbm_pkg::SW_CAP_JOIN] && !sw[sbm_pkg::SW_CAP_GND] && sw[sbm_pkg::SW_CAP_MID]
    |=> bridge_capability_line == sbm_pkg::SBM_LVL_MID)
    else $error("Isolated capability line did not follow the divider.");

  cap_override_a: assert property (
    sw[sbm_pkg::SW_CAP_JOIN] && !mod_above_low
    |=> bridge_capability_line == sbm_pkg::SBM_LVL_GND)
    else $error("Grounding module did not override the joined capability line.");

  m66_force_a: assert property (
    sw[sbm_pkg::SW_M66_GND] |=> !bridge_speed66_enable)
    else $error("Closed speed ground switch left the bridge line high.");

  m66_wired_a: assert property (
    !sw[sbm_pkg::SW_M66_GND] && !(sw[sbm_pkg::SW_M66_JOIN] && !mod_m66)
    |=> bridge_speed66_enable)
    else $error("Released speed66 line did not read one.");

  rate_sel_a: assert property (
    sw[sbm_pkg::SW_RATE] |=> !rate_pair_select)
    else $error("Closed rate switch did not pull the select low.");

  host_role_a: assert property (
    !sw[sbm_pkg::SW_HOST] |=> host_role_oe_n)
    else $error("Host-role strap driven while its switch is open.");

  decode_top_a: assert property (
    !config_held && cap_resolved == sbm_pkg::SBM_LVL_HIGH && sw[sbm_pkg::SW_RATE]
    |=> bus_pcix_mode && bus_freq_mhz == sbm_pkg::FREQ_133)
    else $error("High capability with upper rate did not decode as 133 MHz.");

  width_a: assert property (
    !config_held && sw[sbm_pkg::SW_WIDTH32] |=> !bus_64bit)
    else $error("Closed width switch did not select a 32-bit bus.");

  latch_a: assert property (
    bus_reset_release_s |=> config_held)
    else $error("Configuration not held after bus reset release.");

  hold_stable_a: assert property (
    config_held ##0 held_run_s |=> $stable(bus_freq_mhz) && $stable(bus_pcix_mode)
    && $stable(bus_64bit))
    else $error("Held bus configuration changed outside bus reset.");

endmodule // sbm_strap_ctrl

// >>> sbm_strap_ctrl_tb.sv
// Self-checking bench for the secondary bus strap control block.
`timescale 1ns/10ps
module sbm_strap_ctrl_tb;
  logic                clk, reset_n, sec_reset_n, cap_lo, cap_mid, gnd_oe_n, mid_en;
  logic                sp_in, sp_oe_n, br66, rps, host_oe_n, pcix, w64, held, csel;
  logic                mvalid, mready, massert, mslow, sp_out, host_out;
  logic [7:0]          sw, freq;
  logic [3:0]          mreq, int_n;
  logic [1:0]          mline;
  logic [31:0]         ad;
  sbm_pkg::sbm_level_t cap_line, mlvl;
  int                  errors, total_checks;
  logic [7:0]          fsw [8] = '{8'h26, 8'h2E, 8'h06, 8'h0E, 8'h04, 8'h0C, 8'h00, 8'h08};
  logic [7:0]          ffrq [8] = '{8'h19, 8'h21, 8'h32, 8'h42, 8'h32, 8'h42, 8'h64, 8'h85};
  logic [7:0]          afrq [5] = '{8'h85, 8'h42, 8'h42, 8'h21, 8'h42};
  logic [7:0]          alvl [5] = '{8'h02, 8'h01, 8'h00, 8'h00, 8'h00};

  sbm_strap_ctrl dut_u (.clk(clk), .reset_n(reset_n), .config_switch_bank(sw),
    .module_cap_above_low(cap_lo), .module_cap_above_mid(cap_mid),
    .module_cap_gnd_oe_n(gnd_oe_n), .module_cap_mid_en(mid_en),
    .bridge_capability_line(cap_line), .module_speed66_enable_in(sp_in),
    .module_speed66_enable_out(sp_out), .module_speed66_enable_oe_n(sp_oe_n),
    .bridge_speed66_enable(br66), .rate_pair_select(rps), .host_role_out(host_out),
    .host_role_oe_n(host_oe_n), .sec_reset_n(sec_reset_n), .bus_pcix_mode(pcix),
    .bus_freq_mhz(freq), .bus_64bit(w64), .config_held(held), .module_int_n(int_n),
    .int_msg_valid(mvalid), .int_msg_ready(mready), .int_msg_line(mline),
    .int_msg_assert(massert), .ad_bus(ad), .config_select(csel));

  sbm_pmc_model pmc_u (.mod_level(mlvl), .mod_slow66(mslow), .mod_int_req_n(mreq),
    .cap_gnd_oe_n(gnd_oe_n), .cap_mid_en(mid_en), .speed66_oe_n(sp_oe_n),
    .cap_above_low(cap_lo), .cap_above_mid(cap_mid), .speed66_line(sp_in),
    .int_n(int_n));

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Sets straps, lets them settle, then runs a bus reset to latch the decode.
  task automatic apply(input logic [7:0] s, input logic [7:0] l, input logic slow);
    @(negedge clk);
    sw = s;
    mlvl = sbm_pkg::sbm_level_t'(l[1:0]);
    mslow = slow;
    repeat (4) @(negedge clk);
    sec_reset_n = 1'b0;
    repeat (2) @(negedge clk);
    sec_reset_n = 1'b1;
    repeat (3) @(negedge clk);
    chk("config_held", {7'h00, held}, 8'h01);
  endtask

  // The module pulls its capability and speed66 lines low, which forced settings must ignore.
  task automatic test_forced;
    logic [7:0] s;
    for (int i = 0; i < 8; i++) begin
      s = fsw[i] | {i[1], i[0], 6'h00};
      apply(s, 8'h00, 1'b1);
      chk("bus_freq_mhz", freq, ffrq[i]);
      chk("bus_pcix_mode", {7'h00, pcix}, {7'h00, i >= 4});
      chk("cap_line", {6'h00, cap_line}, i < 4 ? 8'h00 : (i < 6 ? 8'h01 : 8'h02));
      chk("bridge_speed66", {7'h00, br66}, {7'h00, i >= 2});
      chk("rate_pair_select", {7'h00, rps}, {7'h00, !s[3]});
      chk("bus_64bit", {7'h00, w64}, {7'h00, !s[6]});
      chk("host_role_oe_n", {7'h00, host_oe_n}, {7'h00, !s[7]});
      chk("module_cap_gnd_oe_n", {7'h00, gnd_oe_n}, 8'h01);
    end
    $display("Test forced done");
  endtask

  // Joined straps let the module pick the rate.
  task automatic test_auto;
    logic [7:0] s;
    for (int i = 0; i < 5; i++) begin
      s = (i == 4) ? 8'hDD : 8'hD9;
      apply(s, alvl[i], i == 3);
      chk("bus_freq_mhz", freq, afrq[i]);
      chk("bus_pcix_mode", {7'h00, pcix}, {7'h00, i < 2});
      chk("bridge_speed66", {7'h00, br66}, {7'h00, i != 3});
      chk("module_cap_mid_en", {7'h00, mid_en}, {7'h00, i == 4});
    end
    apply(8'hF9, 8'h02, 1'b0);
    chk("bridge_speed66", {7'h00, br66}, 8'h00);
    chk("speed66_oe_n", {7'h00, sp_oe_n}, 8'h00);
    chk("speed66_out", {7'h00, sp_out}, 8'h00);
    chk("host_role_out", {7'h00, host_out}, 8'h00);
    $display("Test auto done");
  endtask

  // Straps moved after the bus reset must not reach the latched decode.
  task automatic test_hold;
    apply(8'h00, 8'h02, 1'b0);
    sw = 8'h26;
    repeat (6) @(negedge clk);
    chk("bus_freq_mhz", freq, 8'h64);
    chk("bus_pcix_mode", {7'h00, pcix}, 8'h01);
    chk("cap_line", {6'h00, cap_line}, 8'h00);
    $display("Test hold done");
  endtask

  // Two lines fall together; the lower index is reported first.
  task automatic test_int;
    mreq = 4'h5;
    repeat (5) @(negedge clk);
    chk("msg", {mvalid, massert, 4'h0, mline}, 8'hC1);
    mready = 1'b1;
    @(negedge clk);
    mready = 1'b0;
    repeat (2) @(negedge clk);
    chk("msg", {mvalid, massert, 4'h0, mline}, 8'hC3);
    mready = 1'b1;
    mreq = 4'hF;
    @(negedge clk);
    mready = 1'b0;
    repeat (5) @(negedge clk);
    chk("msg", {mvalid, massert, 4'h0, mline}, 8'h81);
    $display("Test interrupts done");
  endtask

  task automatic test_idsel;
    for (int i = 0; i < 2; i++) begin
      ad = i ? 32'hFFEF_FFFF : 32'h0010_0000;
      @(negedge clk);
      chk("config_select", {7'h00, csel}, {7'h00, i == 0});
    end
    $display("Test idsel done");
  endtask

  task automatic finish_test;
    $display("Checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Free running 200 MHz clock.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Cuts a hang short; the whole run needs about one microsecond.
  initial begin
    #20us;
    errors++;
    $display("Error watchdog expired");
    finish_test();
  end

  // Main sequence.
  initial begin
    {reset_n, sec_reset_n, mready, mslow, ad} = '0;
    sw = 8'h00;
    mreq = 4'hF;
    mlvl = sbm_pkg::SBM_LVL_HIGH;
    errors = 0;
    total_checks = 0;
    repeat (12) @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    chk("config_held", {7'h00, held}, 8'h00);
    test_forced();
    test_auto();
    test_hold();
    test_int();
    test_idsel();
    finish_test();
  end
endmodule // sbm_strap_ctrl_tb

// >>> sbm_sync.sv
// Two-stage synchroniser for the strap, speed and interrupt pins.
`timescale 1ns/10ps
module sbm_sync #(
  parameter int                WIDTH     = 1,
  parameter logic [WIDTH-1:0]  RESET_VAL = '0
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // Pins and their synchronised copies
  input  wire logic [WIDTH-1:0] pin,
  output logic      [WIDTH-1:0] pin_sync
);

  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } sbm_sync_state_t;

  sbm_sync_state_t cur;
  sbm_sync_state_t next_cur;

  // The first stage feeds only the second stage, so metastability stays contained.
  always_comb begin
    next_cur.first  = pin;
    next_cur.second = cur.first;
  end

  // Register the whole chain.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cur <= '{first: RESET_VAL, second: RESET_VAL};
    end else begin
      cur <= next_cur;
    end
  end

  assign pin_sync = cur.second;

endmodule // sbm_sync
